/* File: design/pics_int_ctl.sv */
`timescale 1ns/1ns
// Functional notes
// - host picks interrupt sources, sees the cause, acknowledges by clearing
// - bit 23 reads as OR of latched flags in bits 19..16
// - bit 21 latches on target abort seen while bus master
// - bit 20 latches on master abort of a device-issued cycle
// - bits 21..16 clear on writing one; zero leaves them; reads show state
// - bit 19 latches when master read byte count reaches zero
// - bit 18 latches when master write byte count reaches zero
// - bit 17 latches on add-on write of selected incoming mailbox byte
// - bit 16 latches on add-on read of selected outgoing mailbox byte
// - bit 15 enables interrupt for read count zero
// - bit 14 enables interrupt for write count zero
// - bit 12 enables interrupt for selected incoming mailbox write
// - bits 11:10 select incoming mailbox one to four
// - bits 9:8 select byte of incoming mailbox
// - bits 31:24 hold fifo and endian control, stored separately
// - bit 4 enables interrupt for selected outgoing mailbox read
// - bits 3:2 and 1:0 select outgoing mailbox and byte
module pics_int_ctl (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reg_sel,
  input wire logic [7:0] reg_offset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_be,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_hit,
  input wire logic rd_count_zero,
  input wire logic wr_count_zero,
  input wire logic [15:0] in_mbox_wr,
  input wire logic [15:0] out_mbox_rd,
  input wire logic target_abort,
  input wire logic master_abort,
  output logic [7:0] fifo_endian_ctl,
  output logic pci_int_n
);
  localparam int FM = pics_pkg::FLAG_LSB;
  localparam int FN = pics_pkg::FLAG_COUNT;

  // configuration fields, each updated only by its own byte lane
  logic [7:0] fifo_ctl_q;
  logic rd_en_q;
  logic wr_en_q;
  logic in_en_q;
  logic [1:0] in_mbox_q;
  logic [1:0] in_byte_q;
  logic out_en_q;
  logic [1:0] out_mbox_q;
  logic [1:0] out_byte_q;
  // flag path: raw events, clear terms, latched flags
  logic [FN-1:0] flags_q;
  logic [FN-1:0] flags_d;
  logic [FN-1:0] events;
  logic [FN-1:0] w1c;
  logic in_hit;
  logic out_hit;
  logic acc_wr;
  logic int_asserted;
  logic int_q;
  logic [31:0] rdata_q;
  logic [31:0] cur;
  logic [FN-1:0] int_en;
  logic wr_top;
  logic wr_mid;
  logic wr_low;

  // byte lane qualified write helper
  function automatic logic lane_wr(input logic [3:0] be, input int bit_pos);
    lane_wr = be[bit_pos / 8];
  endfunction

  // a single word is mapped; other offsets are ignored and read zero
  assign reg_hit = reg_sel && (reg_offset == pics_pkg::ICS_OFFSET);
  assign acc_wr = reg_hit && reg_wr;

  // one strobe per byte lane; a lane left out keeps its fields untouched
  assign wr_top = acc_wr && lane_wr(reg_be, pics_pkg::FIFO_CTL_LSB);
  assign wr_mid = acc_wr && lane_wr(reg_be, pics_pkg::IN_BYTE_SEL_LSB);
  assign wr_low = acc_wr && lane_wr(reg_be, pics_pkg::OUT_BYTE_SEL_LSB);

  // mailbox byte selection is shared logic, one instance each way
  pics_mbox_match u_in_match (
    .byte_strobe(in_mbox_wr),
    .mbox_sel(in_mbox_q),
    .byte_sel(in_byte_q),
    .hit(in_hit)
  );
  pics_mbox_match u_out_match (
    .byte_strobe(out_mbox_rd),
    .mbox_sel(out_mbox_q),
    .byte_sel(out_byte_q),
    .hit(out_hit)
  );

  // event vector in flag-bit order 16..21
  // inputs are one-cycle pulses; a held level keeps setting its flag
  always_comb begin
    events = '0;
    events[pics_pkg::OUT_MBOX_BIT-FM] = out_hit;
    events[pics_pkg::IN_MBOX_BIT-FM] = in_hit;
    events[pics_pkg::WR_DONE_BIT-FM] = wr_count_zero;
    events[pics_pkg::RD_DONE_BIT-FM] = rd_count_zero;
    events[pics_pkg::MST_ABORT_BIT-FM] = master_abort;
    events[pics_pkg::TGT_ABORT_BIT-FM] = target_abort;
  end

  // write-one-to-clear, one term per flag bit; a zero leaves the flag
  for (genvar g = 0; g < FN; g++) begin : g_w1c
    assign w1c[g] = acc_wr && lane_wr(reg_be, FM + g) && reg_wdata[FM + g];
  end

  // a new event in the clear cycle wins, so no event is lost to a clear
  assign flags_d = (flags_q & ~w1c) | events;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  // top byte kept apart from interrupt fields
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fifo_ctl_q <=
        pics_pkg::ICS_RESET[pics_pkg::FIFO_CTL_MSB:pics_pkg::FIFO_CTL_LSB];
    end else if (wr_top) begin
      fifo_ctl_q <= reg_wdata[pics_pkg::FIFO_CTL_MSB:pics_pkg::FIFO_CTL_LSB];
    end
  end
  assign fifo_endian_ctl = fifo_ctl_q;

  // enables and selects, per byte lane
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_en_q <= 1'b0;
      wr_en_q <= 1'b0;
      in_en_q <= 1'b0;
      in_mbox_q <= 2'h0;
      in_byte_q <= 2'h0;
    end else if (wr_mid) begin
      rd_en_q <= reg_wdata[pics_pkg::RD_DONE_EN_BIT];
      wr_en_q <= reg_wdata[pics_pkg::WR_DONE_EN_BIT];
      in_en_q <= reg_wdata[pics_pkg::IN_MBOX_EN_BIT];
      in_mbox_q <= reg_wdata[pics_pkg::IN_MBOX_SEL_LSB +: 2];
      in_byte_q <= reg_wdata[pics_pkg::IN_BYTE_SEL_LSB +: 2];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      out_en_q <= 1'b0;
      out_mbox_q <= 2'h0;
      out_byte_q <= 2'h0;
    end else if (wr_low) begin
      out_en_q <= reg_wdata[pics_pkg::OUT_MBOX_EN_BIT];
      out_mbox_q <= reg_wdata[pics_pkg::OUT_MBOX_SEL_LSB +: 2];
      out_byte_q <= reg_wdata[pics_pkg::OUT_BYTE_SEL_LSB +: 2];
    end
  end

  // summary covers only the four transfer and mailbox flags
  // aborts are left out, so it can read clear while an abort flag
  // still holds the interrupt line low
  assign int_asserted =
    |flags_q[pics_pkg::RD_DONE_BIT-FM:pics_pkg::OUT_MBOX_BIT-FM];

  // per-flag interrupt mask; the aborts have no enable bit, so they
  // always reach the line and software must clear them to drop it
  always_comb begin
    int_en = '0;
    int_en[pics_pkg::OUT_MBOX_BIT-FM] = out_en_q;
    int_en[pics_pkg::IN_MBOX_BIT-FM] = in_en_q;
    int_en[pics_pkg::WR_DONE_BIT-FM] = wr_en_q;
    int_en[pics_pkg::RD_DONE_BIT-FM] = rd_en_q;
    int_en[pics_pkg::MST_ABORT_BIT-FM] = 1'b1;
    int_en[pics_pkg::TGT_ABORT_BIT-FM] = 1'b1;
  end

  // interrupt line is registered, so it trails its flag by one cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      int_q <= 1'b0;
    end else begin
      int_q <= |(flags_q & int_en);
    end
  end
  assign pci_int_n = ~int_q;

  // current register image; reserved bits read zero
  always_comb begin
    cur = '0;
    cur[pics_pkg::FIFO_CTL_MSB:pics_pkg::FIFO_CTL_LSB] = fifo_ctl_q;
    cur[pics_pkg::INT_ASSERTED_BIT] = int_asserted;
    cur[FM +: FN] = flags_q;
    cur[pics_pkg::RD_DONE_EN_BIT] = rd_en_q;
    cur[pics_pkg::WR_DONE_EN_BIT] = wr_en_q;
    cur[pics_pkg::IN_MBOX_EN_BIT] = in_en_q;
    cur[pics_pkg::IN_MBOX_SEL_LSB +: 2] = in_mbox_q;
    cur[pics_pkg::IN_BYTE_SEL_LSB +: 2] = in_byte_q;
    cur[pics_pkg::OUT_MBOX_EN_BIT] = out_en_q;
    cur[pics_pkg::OUT_MBOX_SEL_LSB +: 2] = out_mbox_q;
    cur[pics_pkg::OUT_BYTE_SEL_LSB +: 2] = out_byte_q;
  end

  // read data registered, one cycle after the read strobe
  // and zero otherwise, so a shared read bus can simply OR it in
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_q <= pics_pkg::ICS_RESET;
    end else if (reg_hit && reg_rd) begin
      rdata_q <= cur;
    end else begin
      rdata_q <= 32'h00000000;
    end
  end
  assign reg_rdata = rdata_q;
endmodule

/* File: design/pics_pkg.sv */
package pics_pkg;
  // register map
  localparam logic [7:0] ICS_OFFSET = 8'h38;
  localparam logic [31:0] ICS_RESET = 32'h00000000;
  // field positions
  localparam int FIFO_CTL_MSB = 31;
  localparam int FIFO_CTL_LSB = 24;
  localparam int INT_ASSERTED_BIT = 23;
  localparam int TGT_ABORT_BIT = 21;
  localparam int MST_ABORT_BIT = 20;
  localparam int RD_DONE_BIT = 19;
  localparam int WR_DONE_BIT = 18;
  localparam int IN_MBOX_BIT = 17;
  localparam int OUT_MBOX_BIT = 16;
  localparam int RD_DONE_EN_BIT = 15;
  localparam int WR_DONE_EN_BIT = 14;
  localparam int IN_MBOX_EN_BIT = 12;
  localparam int IN_MBOX_SEL_LSB = 10;
  localparam int IN_BYTE_SEL_LSB = 8;
  localparam int OUT_MBOX_EN_BIT = 4;
  localparam int OUT_MBOX_SEL_LSB = 2;
  localparam int OUT_BYTE_SEL_LSB = 0;
  localparam int FLAG_LSB = 16;
  localparam int FLAG_COUNT = 6;
  localparam int MBOX_BYTES = 16;
endpackage

/* File: design/pics_mbox_match.sv */
`timescale 1ns/1ns
// picks the one byte strobe named by a mailbox and byte select pair
module pics_mbox_match (
  input wire logic [15:0] byte_strobe,
  input wire logic [1:0] mbox_sel,
  input wire logic [1:0] byte_sel,
  output logic hit
);
  // index is mailbox*4+byte, so 00/00 is mailbox one byte 0
  assign hit = byte_strobe[{mbox_sel, byte_sel}];
endmodule

/* File: verification/pics_int_ctl_props.sv */
`timescale 1ns/1ns
// port-level checks on the interrupt control and status register
module pics_int_ctl_props (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reg_sel,
  input wire logic [7:0] reg_offset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_be,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_hit,
  input wire logic target_abort,
  input wire logic master_abort,
  input wire logic [7:0] fifo_endian_ctl,
  input wire logic pci_int_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // a taken read, and a taken write of the top lane
  sequence s_rd; reg_hit && reg_rd; endsequence
  sequence s_top; reg_hit && reg_wr && reg_be[3]; endsequence
  a_hit_decode: assert property (
    reg_hit == (reg_sel && reg_offset == pics_pkg::ICS_OFFSET))
    else $error("bad decode");
  a_rdata_idle: assert property (
    !(reg_hit && reg_rd) |=> reg_rdata == 32'h0) else $error("stray rdata");
  a_summary_or: assert property (
    s_rd |=> reg_rdata[23] == (|reg_rdata[19:16])) else $error("bad summary");
  a_rsvd_zero: assert property (
    s_rd |=> {reg_rdata[22], reg_rdata[13], reg_rdata[7:5]} == 5'h0)
    else $error("reserved bit set");
  a_tabort_int: assert property (
    target_abort |-> ##2 !pci_int_n) else $error("no int on abort");
  a_mabort_int: assert property (
    master_abort |-> ##2 !pci_int_n) else $error("no int on abort");
  a_fifo_load: assert property (
    s_top |=> fifo_endian_ctl == $past(reg_wdata[31:24]))
    else $error("top byte not loaded");
  // reset itself clears the byte, so an attempt begun in reset is vacuous
  a_fifo_hold: assert property (
    !sys_rst && !(reg_hit && reg_wr && reg_be[3])
      |=> $stable(fifo_endian_ctl))
    else $error("top byte moved");
  // the interrupt only lets go two cycles after a register write,
  // apart from the release that reset causes
  a_int_release: assert property (
    $rose(pci_int_n) && !$past(sys_rst) |-> $past(reg_hit && reg_wr, 2))
    else $error("int dropped alone");
endmodule
bind pics_int_ctl pics_int_ctl_props u_props (.sys_clk, .sys_rst, .reg_sel,
  .reg_offset, .reg_wr, .reg_rd, .reg_be, .reg_wdata, .reg_rdata, .reg_hit,
  .target_abort, .master_abort, .fifo_endian_ctl, .pci_int_n);

/* File: verification/pics_addon_model.sv */
`timescale 1ns/1ns
// add-on side and bus engine: one event strobe per request
module pics_addon_model (
  input wire logic sys_clk,
  input wire logic start,
  input wire logic [2:0] kind,
  input wire logic [3:0] idx,
  output logic rd_count_zero,
  output logic wr_count_zero,
  output logic [15:0] in_mbox_wr,
  output logic [15:0] out_mbox_rd,
  output logic target_abort,
  output logic master_abort
);
  // strobes last one cycle, a held level would keep re-setting flags
  always_ff @(posedge sys_clk) begin
    out_mbox_rd <= (start && kind == 3'h0) ? 16'h1 << idx : 16'h0;
    in_mbox_wr <= (start && kind == 3'h1) ? 16'h1 << idx : 16'h0;
    wr_count_zero <= start && kind == 3'h2;
    rd_count_zero <= start && kind == 3'h3;
    master_abort <= start && kind == 3'h4;
    target_abort <= start && kind == 3'h5;
  end
endmodule

/* File: verification/pics_int_ctl_tb.sv */
`timescale 1ns/1ns
module pics_int_ctl_tb;
  logic sys_clk = 1'b0, sys_rst = 1'b1, reg_sel = 1'b0, reg_wr = 1'b0;
  logic reg_rd = 1'b0, start = 1'b0, rd_seen = 1'b0;
  logic [7:0] reg_offset = 8'h0, sel, fifo_endian_ctl;
  logic [3:0] reg_be = 4'h0, idx = 4'h0, pick;
  logic [2:0] kind = 3'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, cfg, img, exp_q[$];
  logic [15:0] in_mbox_wr, out_mbox_rd;
  logic reg_hit, rd_count_zero, wr_count_zero, target_abort, master_abort;
  logic pci_int_n;
  int n_errors = 0, comparisons = 0;
  always #4 sys_clk = ~sys_clk;
  pics_int_ctl u_dut (.sys_clk, .sys_rst, .reg_sel, .reg_offset, .reg_wr,
    .reg_rd, .reg_be, .reg_wdata, .reg_rdata, .reg_hit, .rd_count_zero,
    .wr_count_zero, .in_mbox_wr, .out_mbox_rd, .target_abort, .master_abort,
    .fifo_endian_ctl, .pci_int_n);
  pics_addon_model u_addon (.sys_clk, .start, .kind, .idx, .rd_count_zero,
    .wr_count_zero, .in_mbox_wr, .out_mbox_rd, .target_abort, .master_abort);
  task automatic summarize();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  // one access cycle; strobes drop at the edge that takes them
  task automatic acc(logic wr, logic [7:0] o, logic [3:0] b, logic [31:0] d);
    @(posedge sys_clk);
    {reg_sel, reg_wr, reg_rd, reg_offset, reg_be, reg_wdata} <=
      {1'b1, wr, !wr, o, b, d};
    @(posedge sys_clk);
    {reg_sel, reg_wr, reg_rd} <= 3'h0;
  endtask
  task automatic rd(input logic [7:0] o, input logic [31:0] e);
    exp_q.push_back(e);
    acc(1'b0, o, 4'h0, 32'h0);
  endtask
  // event strobe, then time for flag and interrupt register to follow
  task automatic fire(input logic [2:0] k, input logic [3:0] i);
    @(posedge sys_clk);
    {start, kind, idx} <= {1'b1, k, i};
    @(posedge sys_clk);
    start <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  // read data lands at the taken edge, compared mid-cycle after it
  always @(posedge sys_clk) rd_seen <= reg_sel && reg_rd;
  always @(negedge sys_clk) if (rd_seen) begin
    check("rdata", reg_rdata, exp_q.pop_front());
  end
  initial begin
    repeat (4000) @(posedge sys_clk);
    n_errors++;
    summarize();
  end
  initial begin
    void'($urandom(32'hF039EAB8));
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(8'h38, 32'h0);
    acc(1'b1, 8'h38, 4'hF, 32'hFFFFFFFF);
    acc(1'b1, 8'h3C, 4'hF, 32'h0);
    rd(8'h3C, 32'h0);
    rd(8'h38, 32'hFF00DF1F);
    sel = 8'($urandom);
    cfg = {16'hFF00, 4'hD, sel[7:4], 4'h1, sel[3:0]};
    // top byte sent as zero with its lane off, so it must keep FF
    acc(1'b1, 8'h38, 4'h3, cfg ^ 32'hFFFF0000);
    for (int k = 0; k < 6; k++) begin
      pick = k == 0 ? sel[3:0] : sel[7:4];
      if (k < 2) begin
        // wrong byte, then wrong mailbox: neither may latch
        fire(k[2:0], pick ^ 4'h1);
        fire(k[2:0], pick ^ 4'h4);
        check("int", pci_int_n, 1'b1);
        rd(8'h38, cfg);
      end
      fire(k[2:0], pick);
      check("int", pci_int_n, 1'b0);
      img = cfg | (32'h1 << (16 + k)) | (k < 4 ? 32'h00800000 : 32'h0);
      rd(8'h38, img);
      acc(1'b1, 8'h38, 4'h4, ~(32'h1 << (16 + k)));
      rd(8'h38, img);
      acc(1'b1, 8'h38, 4'h4, 32'h1 << (16 + k));
      repeat (2) @(posedge sys_clk);
      #1;
      check("int", pci_int_n, 1'b1);
      rd(8'h38, cfg);
    end
    // masked source latches but stays quiet
    acc(1'b1, 8'h38, 4'h3, 32'h0);
    fire(3'h3, 4'h0);
    check("int", pci_int_n, 1'b1);
    rd(8'h38, 32'hFF880000);
    // an abort needs no enable, and reset must drop the line it holds
    fire(3'h5, 4'h0);
    check("int", pci_int_n, 1'b0);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(8'h38, 32'h0);
    // let the last read reach its compare before the verdict
    repeat (2) @(posedge sys_clk);
    #1;
    check("int", pci_int_n, 1'b1);
    check("queue", 32'(exp_q.size()), 32'h0);
    summarize();
  end
endmodule
